// >>> pdm_pkg.sv
// Package for the power-down mode controller: power control register layout,
// state encoding and timing counts.
// Assumes a single 25 MHz system clock and a CPU core that honours the
// stall, vector and RAM-block outputs of the controller.
// Operation
// - Setting power-down bit stops instruction execution
// - Enabled wake line a or b ends power-down
// - Interrupt wake clears bit, restarts clocks
// - Hold execution until wake line released
// - Interrupt wake resumes in service routine
// - Interrupt wake keeps registers and RAM
// - Reset pin clears bit asynchronously, restores clocks
// - Reset wake runs briefly, then vectors zero
// - Block RAM access during resumed execution
// - Reset wake reinitialises registers, keeps RAM
// - Power-down drives both strobes low, holds ports, floats port 0 with external code
// - Power-down bit 1, idle bit 0
// - Both bits set selects power-down
// - Power-down stops oscillator, freezes clocks, retains state
package pdm_pkg;

   // ****************************************************************
   // Power control register layout
   // ****************************************************************
   localparam int unsigned PCR_WIDTH = 8;
   localparam int unsigned PCR_IDLE_BIT = 0;
   localparam int unsigned PCR_PD_BIT = 1;
   localparam int unsigned PCR_GF0_BIT = 2;
   localparam int unsigned PCR_GF1_BIT = 3;
   localparam logic [7:0] PCR_RESET = 8'h00;
   localparam logic [7:0] PCR_WRITE_MASK = 8'h0f;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_MHZ = 25;
   // Cycles the oscillator needs after restart before clocks are granted
   localparam int unsigned OSC_START_NS = 1000;
   localparam int unsigned OSC_START_CYC = (OSC_START_NS * CLK_MHZ + 999) / 1000;
   // Brief resumed execution before the internal reset takes over
   localparam int unsigned RST_RUN_CYC = 4;
   localparam int unsigned CNT_W = 8;

   // ****************************************************************
   // States
   // ****************************************************************
   typedef enum logic [6:0] {
      PDM_RUN = 7'h01,
      PDM_IDLE = 7'h02,
      PDM_DOWN = 7'h04,
      PDM_OSC = 7'h08,
      PDM_HOLD = 7'h10,
      PDM_RRUN = 7'h20,
      PDM_RINIT = 7'h40
   } pdm_state_e;

   typedef struct packed {
      logic alive_a;
      logic alive_b;
   } pdm_wake_s;

   typedef struct packed {
      logic stall;
      logic clk_cpu_en;
      logic clk_per_en;
      logic osc_en;
      logic ale;
      logic program_store_strobe;
      logic p0_float;
      logic ram_block;
      logic int_req;
      logic core_reset;
      logic vector_valid;
   } pdm_ctl_s;

endpackage : pdm_pkg

// >>> pdm_wake_sense.sv
// Clockless wake detector for the two active-low external lines.
// Assumes the lines are stable levels from the pads; this path is
// combinational so it works while the oscillator is stopped.
`timescale 1ns/1ps
module pdm_wake_sense (
   // Pads and enables
   input wire logic i_wake_a_n,
   input wire logic i_wake_b_n,
   input wire logic i_en_a,
   input wire logic i_en_b,
   // Wake request
   output pdm_pkg::pdm_wake_s o_wake
);

   // No clock: a stopped oscillator cannot hide the level
   assign o_wake.alive_a = i_en_a & ~i_wake_a_n;
   assign o_wake.alive_b = i_en_b & ~i_wake_b_n;

endmodule // pdm_wake_sense

// >>> pdm_ctrl.sv
// Power-down and idle mode controller: mode entry, wake-up by external
// interrupt or reset pin, clock and strobe control.
// Assumes the core pulses i_pcr_we with data on the instruction that
// writes the power control register, and stops on o_ctl.stall.
`timescale 1ns/1ps
module pdm_ctrl (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Core side
   input wire logic i_pcr_we,
   input wire logic [7:0] i_pcr_wdata,
   input wire logic i_ext_code,
   input wire logic i_irq_taken,
   // Wake pins and enables
   input wire logic i_wake_a_n,
   input wire logic i_wake_b_n,
   input wire logic i_en_a,
   input wire logic i_en_b,
   input wire logic i_rst_pin,
   // Outputs
   output logic [7:0] o_pcr,
   output pdm_pkg::pdm_ctl_s o_ctl,
   output logic [15:0] o_vector,
   output logic o_in_power_down
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      pdm_pkg::pdm_state_e st;
      logic [7:0] pcr;
      // Shared by oscillator start and the brief run after a reset pin
      logic [pdm_pkg::CNT_W-1:0] cnt;
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic [1:0] sync_r;
      pdm_pkg::pdm_ctl_s ctl;
      logic pd_out;
      logic [15:0] vec;
   } pdm_st_s;

   pdm_st_s r;
   pdm_st_s next_r;
   // Raw pin-side wake, valid while the oscillator is stopped
   pdm_pkg::pdm_wake_s wake;
   logic wake_any;
   logic line_low;

   pdm_wake_sense u_wake (
      .i_wake_a_n(i_wake_a_n),
      .i_wake_b_n(i_wake_b_n),
      .i_en_a(i_en_a),
      .i_en_b(i_en_b),
      .o_wake(wake)
   );

   // Clockless wake sensed directly; fine in stopped-clock state
   assign wake_any = wake.alive_a | wake.alive_b;
   // Release is judged on synchronised levels only,
   // so a glitch on a released line cannot restart the routine
   assign line_low = (i_en_a & ~r.sync_a[1]) | (i_en_b & ~r.sync_b[1]);

   // Control outputs of normal running; decoded in two places
   function automatic pdm_pkg::pdm_ctl_s run_ctl(input logic ext_code);
      pdm_pkg::pdm_ctl_s c;
      c = '0;
      c.clk_cpu_en = 1'b1;
      c.clk_per_en = 1'b1;
      c.osc_en = 1'b1;
      c.ale = 1'b1;
      c.program_store_strobe = 1'b1;
      c.p0_float = 1'b0;
      return c;
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_r = r;
      next_r.sync_a = {r.sync_a[0], i_wake_a_n};
      next_r.sync_b = {r.sync_b[0], i_wake_b_n};
      next_r.sync_r = {r.sync_r[0], i_rst_pin};
      next_r.ctl = run_ctl(i_ext_code);
      next_r.ctl.int_req = 1'b0;
      next_r.ctl.vector_valid = 1'b0;
      next_r.pd_out = 1'b0;
      if (r.cnt != '0) begin
         next_r.cnt = r.cnt - 1'b1;
      end
      case (r.st)
         pdm_pkg::PDM_RUN: begin
            // Writes land only while running; a stalled core cannot issue one
            if (i_pcr_we) begin
               next_r.pcr = i_pcr_wdata & pdm_pkg::PCR_WRITE_MASK;
               if (i_pcr_wdata[pdm_pkg::PCR_PD_BIT]) begin
                  next_r.st = pdm_pkg::PDM_DOWN;
               end else if (i_pcr_wdata[pdm_pkg::PCR_IDLE_BIT]) begin
                  next_r.st = pdm_pkg::PDM_IDLE;
               end
            end
         end
         pdm_pkg::PDM_IDLE: begin
            next_r.ctl.stall = 1'b1;
            next_r.ctl.clk_cpu_en = 1'b0;
            // Peripherals keep their clock; only the core waits
            next_r.ctl.p0_float = i_ext_code;
            if (wake_any | i_irq_taken) begin
               next_r.pcr[pdm_pkg::PCR_IDLE_BIT] = 1'b0;
               next_r.st = pdm_pkg::PDM_RUN;
            end
         end
         pdm_pkg::PDM_DOWN: begin
            // Oscillator off, clocks frozen, state retained
            next_r.ctl.stall = 1'b1;
            next_r.ctl.clk_cpu_en = 1'b0;
            next_r.ctl.clk_per_en = 1'b0;
            next_r.ctl.osc_en = 1'b0;
            next_r.ctl.ale = 1'b0;
            next_r.ctl.program_store_strobe = 1'b0;
            next_r.ctl.p0_float = i_ext_code;
            next_r.pd_out = 1'b1;
            if (wake_any) begin
               // Registers and RAM untouched on this path
               next_r.pcr[pdm_pkg::PCR_PD_BIT] = 1'b0;
               next_r.pcr[pdm_pkg::PCR_IDLE_BIT] = 1'b0;
               next_r.ctl.osc_en = 1'b1;
               next_r.cnt = pdm_pkg::CNT_W'(pdm_pkg::OSC_START_CYC);
               next_r.st = pdm_pkg::PDM_OSC;
            end
         end
         pdm_pkg::PDM_OSC: begin
            // Clocks stay gated until the restarted oscillator has settled
            next_r.ctl.stall = 1'b1;
            next_r.ctl.clk_cpu_en = 1'b0;
            next_r.ctl.clk_per_en = 1'b0;
            if (r.cnt == '0) begin
               next_r.st = pdm_pkg::PDM_HOLD;
            end
         end
         pdm_pkg::PDM_HOLD: begin
            // Level wake: resuming while a line is low would re-enter the routine
            next_r.ctl.stall = 1'b1;
            if (!line_low) begin
               next_r.ctl.stall = 1'b0;
               next_r.ctl.int_req = 1'b1;
               next_r.st = pdm_pkg::PDM_RUN;
            end
         end
         pdm_pkg::PDM_RRUN: begin
            // Port pins stay usable; only the internal RAM is fenced off
            next_r.ctl.ram_block = 1'b1;
            if (r.cnt == '0) begin
               next_r.st = pdm_pkg::PDM_RINIT;
            end
         end
         pdm_pkg::PDM_RINIT: begin
            // Reinitialise control registers; RAM is outside this block
            next_r.pcr = pdm_pkg::PCR_RESET;
            next_r.ctl.core_reset = 1'b1;
            next_r.ctl.vector_valid = 1'b1;
            next_r.vec = pdm_pkg::RESET_VECTOR;
            next_r.ctl.stall = 1'b1;
            if (!r.sync_r[1]) begin
               next_r.st = pdm_pkg::PDM_RUN;
            end
         end
         default: begin
            // Unreachable code: fall back to running
            next_r.st = pdm_pkg::PDM_RUN;
         end
      endcase
      // Reset pin wake from power-down; clears bit without waiting
      // Placed after the case so the pin outranks a wake in the same cycle
      if (r.sync_r[1] && (r.st == pdm_pkg::PDM_DOWN || r.st == pdm_pkg::PDM_IDLE)) begin
         next_r.ctl = run_ctl(i_ext_code);
         next_r.ctl.ram_block = 1'b1;
         next_r.pcr[pdm_pkg::PCR_PD_BIT] = 1'b0;
         next_r.pcr[pdm_pkg::PCR_IDLE_BIT] = 1'b0;
         next_r.cnt = pdm_pkg::CNT_W'(pdm_pkg::RST_RUN_CYC);
         next_r.st = pdm_pkg::PDM_RRUN;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // The reset pin is a wake source here, not a register reset
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r.st <= pdm_pkg::PDM_RUN;
         r.pcr <= pdm_pkg::PCR_RESET;
         r.cnt <= '0;
         // Idle pin levels, so no false wake follows reset
         r.sync_a <= 2'h3;
         r.sync_b <= 2'h3;
         r.sync_r <= 2'h0;
         r.ctl <= '0;
         r.pd_out <= 1'b0;
         r.vec <= pdm_pkg::RESET_VECTOR;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Bit cleared at once by the pin, without the clock; the register
   // copy follows once the pin has passed its synchroniser
   always_comb begin
      o_pcr = r.pcr;
      if (i_rst_pin) begin
         o_pcr[pdm_pkg::PCR_PD_BIT] = 1'b0;
      end
   end
   assign o_ctl = r.ctl;
   assign o_vector = r.vec;
   assign o_in_power_down = r.pd_out;

endmodule // pdm_ctrl

// >>> pdm_ctrl_asserts.sv
// Port checker for the power-down controller.
// Assumes binding to pdm_ctrl; sees its ports only.
`timescale 1ns/1ps
module pdm_ctrl_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Wake side
   input wire logic i_wake_a_n,
   input wire logic i_wake_b_n,
   input wire logic i_en_a,
   input wire logic i_en_b,
   input wire logic i_rst_pin,
   // Outputs
   input wire logic [7:0] o_pcr,
   input wire pdm_pkg::pdm_ctl_s o_ctl,
   input wire logic [15:0] o_vector,
   input wire logic o_in_power_down
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // ****************************************************************
   // Sequences
   // ****************************************************************
   sequence s_wake_start;
      $rose(o_ctl.osc_en) && $past(o_ctl.stall) && o_ctl.stall;
   endsequence
   sequence s_rst_run;
      o_ctl.ram_block [*6];
   endsequence
   // ****************************************************************
   // Properties
   // ****************************************************************
   a_entry_stall: assert property ($rose(o_in_power_down) |-> o_ctl.stall && !o_ctl.osc_en && !o_ctl.clk_cpu_en) else $error("entry not stalled");
   a_strobe_low: assert property (o_in_power_down && !o_ctl.osc_en |-> !o_ctl.ale && !o_ctl.program_store_strobe) else $error("strobes not low");
   a_rst_clear: assert property (i_rst_pin |-> !o_pcr[1]) else $error("pin left bit set");
   a_vector_zero: assert property (o_ctl.vector_valid |-> o_ctl.core_reset && o_vector == 16'h0000) else $error("bad vector");
   a_release_first: assert property (o_ctl.int_req |-> $past(i_wake_a_n | !i_en_a) && $past(i_wake_b_n | !i_en_b)) else $error("resumed while line low");
   a_osc_settle: assert property (s_wake_start |-> o_ctl.stall [*8]) else $error("ran before settle");
   a_wake_clear: assert property (s_wake_start |-> o_pcr[1:0] == 2'b00) else $error("bit not cleared");
   a_ram_block: assert property ($rose(o_ctl.ram_block) |-> s_rst_run ##1 o_ctl.core_reset) else $error("ram block span");
   a_pcr_upper: assert property (1'b1 |-> o_pcr[7:4] == 4'h0) else $error("upper bits set");
endmodule // pdm_ctrl_chk
bind pdm_ctrl pdm_ctrl_chk pdm_ctrl_chk_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_wake_a_n(i_wake_a_n), .i_wake_b_n(i_wake_b_n), .i_en_a(i_en_a), .i_en_b(i_en_b),
   .i_rst_pin(i_rst_pin), .o_pcr(o_pcr), .o_ctl(o_ctl), .o_vector(o_vector),
   .o_in_power_down(o_in_power_down));

// >>> pdm_wake_src.sv
// Model of the external wake source on two pulled-up lines.
// Assumes the bench requests one low pulse at a time.
`timescale 1ns/1ps
module pdm_wake_src (
   // Control
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic i_sel,
   input wire logic [7:0] i_hold,
   // Lines
   output logic o_wake_a_n,
   output logic o_wake_b_n
);
   int cnt = 0;
   // Held low past oscillator start-up, released to pull-up
   always @(negedge i_clk) begin
      if (i_go) cnt = i_hold;
      else if (cnt > 0) cnt = cnt - 1;
   end
   assign o_wake_a_n = !(cnt > 0 && !i_sel);
   assign o_wake_b_n = !(cnt > 0 && i_sel);
endmodule // pdm_wake_src

// >>> power_down_mode_control_bench.sv
// Self-checking bench for pdm_ctrl with a wake source model.
// Assumes checker bound by its own file.
`timescale 1ns/1ps
module power_down_mode_control_bench;
   logic i_clk = 0, i_sys_rst = 1, i_pcr_we = 0, i_ext_code = 0, i_irq_taken = 0;
   logic i_en_a = 0, i_en_b = 0, i_rst_pin = 0, go = 0, sel = 0;
   logic [7:0] i_pcr_wdata = 8'h00, hold = 8'h00, o_pcr, mpcr;
   logic wake_a_n, wake_b_n, o_in_power_down;
   logic [15:0] o_vector;
   pdm_pkg::pdm_ctl_s o_ctl;
   int failures = 0, cmp_count = 0;
   pdm_ctrl pdm_ctrl_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pcr_we(i_pcr_we),
      .i_pcr_wdata(i_pcr_wdata), .i_ext_code(i_ext_code), .i_irq_taken(i_irq_taken),
      .i_wake_a_n(wake_a_n), .i_wake_b_n(wake_b_n), .i_en_a(i_en_a), .i_en_b(i_en_b),
      .i_rst_pin(i_rst_pin), .o_pcr(o_pcr), .o_ctl(o_ctl), .o_vector(o_vector),
      .o_in_power_down(o_in_power_down));
   pdm_wake_src pdm_wake_src_inst (.i_clk(i_clk), .i_go(go), .i_sel(sel), .i_hold(hold),
      .o_wake_a_n(wake_a_n), .o_wake_b_n(wake_b_n));
   initial forever #20 i_clk = ~i_clk;
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task pcr_write(input logic [7:0] d);
      i_pcr_we <= 1'b1;
      i_pcr_wdata <= d;
      tick(1);
      i_pcr_we <= 1'b0;
      tick(1);
   endtask
   task pulse(input logic s, input logic [7:0] h);
      sel <= s;
      hold <= h;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
   endtask
   // Polls after each rising edge; one-cycle pulses are caught there
   task wait_for(input int w);
      int k;
      k = 0;
      while ((w == 0 ? o_ctl.int_req : w == 1 ? o_ctl.ram_block : o_ctl.core_reset) !== 1'b1
             && k < 300) begin
         @(posedge i_clk);
         #1;
         k++;
      end
      check(16'(k < 300), 16'h0001);
      tick(1);
   endtask
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      #(40 * 5000);
      failures++;
      complete_run();
   end
   initial begin
      void'($urandom(62701));
      tick(6);
      i_sys_rst <= 1'b0;
      tick(2);
      check(16'(o_pcr), 16'h0000);
      $display("test reset done");
      for (int s = 0; s < 2; s++) begin
         mpcr = {4'h0, 2'($urandom), 1'b1, 1'($urandom)};
         i_ext_code <= 1'(s);
         i_en_a <= (s == 0);
         i_en_b <= (s == 1);
         pcr_write(mpcr);
         check(16'(o_in_power_down), 16'h0001);
         check(16'({o_ctl.stall, o_ctl.ale, o_ctl.program_store_strobe, o_ctl.osc_en}), 16'h0008);
         check(16'(o_ctl.p0_float), 16'(i_ext_code));
         check(16'(o_pcr), 16'(mpcr));
         pcr_write(8'h00);
         pulse(s == 0, 8'd5);
         tick(12);
         check(16'({o_in_power_down, o_pcr}), 16'({1'b1, mpcr}));
         pulse(s == 1, 8'd40);
         wait_for(0);
         mpcr = mpcr & 8'hfc;
         check(16'({o_ctl.stall, o_in_power_down, o_pcr}), 16'({2'b00, mpcr}));
         $display("test wake line %0d done", s);
      end
      pcr_write(8'h01);
      check(16'({o_in_power_down, o_ctl.ale, o_ctl.program_store_strobe}), 16'h0003);
      check(16'(o_ctl.p0_float), 16'(i_ext_code));
      i_irq_taken <= 1'b1;
      tick(1);
      i_irq_taken <= 1'b0;
      tick(3);
      check(16'(o_pcr[1:0]), 16'h0000);
      $display("test idle done");
      pcr_write(8'h0f);
      check(16'(o_in_power_down), 16'h0001);
      i_rst_pin <= 1'b1;
      #1;
      check(16'(o_pcr[1]), 16'h0000);
      wait_for(1);
      wait_for(2);
      check(16'(o_ctl.vector_valid), 16'h0001);
      check(o_vector, 16'h0000);
      check(16'(o_pcr), 16'h0000);
      i_rst_pin <= 1'b0;
      tick(4);
      check(16'(o_ctl.core_reset), 16'h0000);
      $display("test reset pin done");
      complete_run();
   end
endmodule // power_down_mode_control_bench
